// ==== node_regs_pkg.sv ====
// Constants, field layouts and carrier types for the serial node configuration
// and diagnostic register bank.
// Assumes a protocol engine that hands decoded register accesses to the bank.
package node_regs_pkg;

  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [15:0] ADDR_IDENTITY  = 16'h7531;
  localparam logic [15:0] ADDR_NODE_SW   = 16'h7532;
  localparam logic [15:0] ADDR_CFG_SW    = 16'h7533;
  localparam logic [15:0] ADDR_RX_CNT    = 16'h7534;
  localparam logic [15:0] ADDR_ERR_CNT   = 16'h7536;
  localparam logic [15:0] ADDR_TX_CNT    = 16'h7538;
  localparam logic [15:0] ADDR_UPTIME    = 16'h753C;
  localparam logic [15:0] ADDR_STOP_BITS = 16'h7542;
  localparam logic [15:0] ADDR_DATA_BITS = 16'h7543;
  localparam logic [15:0] ADDR_PARITY    = 16'h7544;
  localparam logic [15:0] ADDR_ACTION    = 16'h9C41;
  localparam logic [15:0] ADDR_LINE_RATE = 16'h9C51;

  // ****************************************
  // Field positions and values
  // ****************************************
  localparam int          IDENT_TYPE_LSB  = 0;
  localparam int          IDENT_VER_LSB   = 8;
  localparam logic [7:0]  FW_SCALE        = 8'h0A;
  localparam logic [15:0] LINE_RATE_RESET = 16'h1E00;
  localparam logic [19:0] RATE_MULT       = 20'h0_000A;
  localparam logic [15:0] STOP_BITS_VAL   = 16'h0001;
  localparam logic [15:0] DATA_BITS_VAL   = 16'h0008;
  localparam logic [15:0] PARITY_VAL      = 16'h0000;
  localparam logic [2:0]  RATE_SW_ALL_OFF = 3'h0;

  // Action codes
  localparam logic [15:0] CODE_RESET    = 16'h01FF;
  localparam logic [15:0] CODE_RELOAD   = 16'h02FF;
  localparam logic [15:0] CODE_DEFAULTS = 16'h03FF;
  localparam logic [15:0] CODE_BOOT     = 16'h04FF;

  // ****************************************
  // Timing
  // ****************************************
  localparam int SECOND_NS     = 1000000000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int SECOND_CYCLES = SECOND_NS / CLK_PERIOD_NS;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    ACT_NONE     = 3'b000,
    ACT_RESET    = 3'b001,
    ACT_RELOAD   = 3'b010,
    ACT_DEFAULTS = 3'b011,
    ACT_BOOT     = 3'b100
  } action_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic rx_good;
    logic err_reply;
    logic tx_frame;
  } frame_events_t;

  typedef struct packed {
    logic reset;
    logic reload;
    logic defaults;
    logic bootloader;
  } action_pulse_t;

endpackage : node_regs_pkg

// ==== frame_counter.sv ====
// Event counter with synchronous clear; an event in the clear cycle counts.
// Assumes single-cycle event pulses on sys_clk.
`timescale 1ns/1ps
module frame_counter #(
  parameter int WIDTH = 32
) (
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  input  wire logic             clear,
  input  wire logic             inc,
  output logic      [WIDTH-1:0] count
);

  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;

  // Next count: clear first, then the event so it is never lost
  always_comb begin
    count_next = clear ? '0 : count_reg;
    if (inc) begin
      count_next = count_next + 1'b1;
    end
  end

  // Counter state
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign count = count_reg;

endmodule : frame_counter

// ==== node_config_regs.sv ====
// Configuration and diagnostic register bank of a serial lighting node.
// Assumes the protocol engine presents one decoded register access per cycle
// and pulses frame events for one cycle each.
// Behaviour
// - Identity word: type code low byte, firmware version times ten high byte.
// - Action writes 511 reset, 767 reload, 1023 defaults, 1279 bootloader.
// - Address switch setting is readable live.
// - Configuration switch setting is readable live as an integer.
// - 32-bit counter of valid received request frames.
// - 32-bit counter of transmitted error replies.
// - 32-bit counter of all transmitted messages.
// - Frame counters clear on power-up and on line parameter change.
// - 16-bit uptime counts seconds since power-up or reset.
// - Line-rate register sets speed only when rate switch sections 1-3 off.
// - Bit rate equals register value times ten; default 7680.
// - Exactly one stop bit; stop-bit register reads one.
// - Written transmission settings apply only after restart; switches apply live.
// - Eight data bits; data-bit register reads eight.
// - No parity; parity register reads zero.
`timescale 1ns/1ps
module node_config_regs
  import node_regs_pkg::*;
#(
  parameter logic [7:0] MODULE_TYPE      = 8'h5A, // Arbitrary type code
  parameter int         FW_MAJOR         = 1,
  parameter int         FW_MINOR         = 0,
  parameter int         SECOND_CYCLES_P  = SECOND_CYCLES
) (
  input  wire logic          sys_clk,
  input  wire logic          reset_n,
  input  reg_req_t           reg_req,
  output logic        [15:0] reg_rdata,
  output logic               reg_ack,
  output logic               reg_err,
  input  wire logic   [7:0]  address_switch,
  input  wire logic   [7:0]  config_switch,
  input  wire logic   [2:0]  rate_selector_switch,
  input  frame_events_t      frame_events,
  output action_pulse_t      action_pulse,
  output logic        [19:0] line_rate_bps,
  output logic               rate_from_register,
  output logic        [3:0]  char_data_bits,
  output logic        [1:0]  char_stop_bits,
  output logic               parity_on
);

  // ****************************************
  // Declarations
  // ****************************************
  localparam logic [7:0] FW_X10 = 8'(FW_MAJOR) * FW_SCALE + 8'(FW_MINOR);
  localparam logic [15:0] IDENT_WORD = {FW_X10, MODULE_TYPE};

  logic [15:0]   line_rate_setting_reg, line_rate_setting_next;
  logic [15:0]   applied_rate_reg, applied_rate_next;
  logic [15:0]   rdata_reg, rdata_next;
  logic          ack_reg, ack_next;
  logic          err_reg, err_next;
  action_t       action_reg, action_next;
  logic [23:0]   tick_cnt_reg, tick_cnt_next;
  logic [15:0]   uptime_reg, uptime_next;
  logic [19:0]   rate_cfg_reg, rate_cfg_next;
  logic          cfg_seen_reg, cfg_seen_next;
  logic          second_tick;
  logic          clear_counters;
  logic          req_any;
  logic [19:0]   rate_cfg_now;
  logic [2:0]    event_vec;
  logic [31:0]   counts [3];

  assign req_any   = reg_req.rd | reg_req.wr;
  assign event_vec = {frame_events.rx_good, frame_events.err_reply, frame_events.tx_frame};

  // ****************************************
  // Frame counters
  // ****************************************
  // Index 2 received, 1 error replies, 0 transmitted
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_cnt
      frame_counter #(.WIDTH(32)) u_cnt (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .clear   (clear_counters),
        .inc     (event_vec[gi]),
        .count   (counts[gi])
      );
    end
  endgenerate

  // Line parameter change detection over switch selection and applied rate
  assign rate_cfg_now   = {rate_selector_switch, (rate_selector_switch == RATE_SW_ALL_OFF), applied_rate_reg};
  assign clear_counters = cfg_seen_reg && (rate_cfg_now != rate_cfg_reg);

  always_comb begin
    rate_cfg_next = rate_cfg_now;
    cfg_seen_next = 1'b1;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rate_cfg_reg <= 20'h0_0000;
      cfg_seen_reg <= 1'b0;
    end else begin
      rate_cfg_reg <= rate_cfg_next;
      cfg_seen_reg <= cfg_seen_next;
    end
  end

  // ****************************************
  // Uptime seconds
  // ****************************************
  assign second_tick = (tick_cnt_reg == 24'(SECOND_CYCLES_P - 1));

  always_comb begin
    tick_cnt_next = second_tick ? 24'h00_0000 : tick_cnt_reg + 24'h00_0001;
    uptime_next   = second_tick ? uptime_reg + 16'h0001 : uptime_reg;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt_reg <= 24'h00_0000;
      uptime_reg   <= 16'h0000;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      uptime_reg   <= uptime_next;
    end
  end

  // ****************************************
  // Register writes and actions
  // ****************************************
  always_comb begin
    line_rate_setting_next = line_rate_setting_reg;
    applied_rate_next      = applied_rate_reg;
    action_next            = ACT_NONE;
    if (reg_req.wr && reg_req.addr == ADDR_LINE_RATE) begin
      line_rate_setting_next = reg_req.wdata; // Stored only
    end else if (reg_req.wr && reg_req.addr == ADDR_ACTION) begin
      if (reg_req.wdata == CODE_RESET) begin
        action_next = ACT_RESET;
      end else if (reg_req.wdata == CODE_RELOAD) begin
        action_next = ACT_RELOAD;
      end else if (reg_req.wdata == CODE_DEFAULTS) begin
        action_next = ACT_DEFAULTS;
      end else if (reg_req.wdata == CODE_BOOT) begin
        action_next = ACT_BOOT;
      end else begin
        action_next = ACT_NONE;
      end
    end
    // Reload acts as the settings restart; defaults reset the stored value to LINE_RATE_RESET, applied rate kept
    case (action_reg)
      ACT_RELOAD:   applied_rate_next = line_rate_setting_reg;
      ACT_DEFAULTS: line_rate_setting_next = LINE_RATE_RESET;
      default:      applied_rate_next = applied_rate_reg;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      line_rate_setting_reg <= LINE_RATE_RESET;
      applied_rate_reg      <= LINE_RATE_RESET;
      action_reg            <= ACT_NONE;
    end else begin
      line_rate_setting_reg <= line_rate_setting_next;
      applied_rate_reg      <= applied_rate_next;
      action_reg            <= action_next;
    end
  end

  // One-cycle action strobes
  assign action_pulse.reset      = (action_reg == ACT_RESET);
  assign action_pulse.reload     = (action_reg == ACT_RELOAD);
  assign action_pulse.defaults   = (action_reg == ACT_DEFAULTS);
  assign action_pulse.bootloader = (action_reg == ACT_BOOT);

  // ****************************************
  // Register reads
  // ****************************************
  always_comb begin
    rdata_next = 16'h0000;
    err_next   = 1'b0;
    ack_next   = req_any;
    if (reg_req.wr) begin
      err_next = !(reg_req.addr == ADDR_LINE_RATE || reg_req.addr == ADDR_ACTION);
    end else if (reg_req.addr == ADDR_IDENTITY) begin
      rdata_next = IDENT_WORD;
    end else if (reg_req.addr == ADDR_NODE_SW) begin
      rdata_next = {8'h00, address_switch};
    end else if (reg_req.addr == ADDR_CFG_SW) begin
      rdata_next = {8'h00, config_switch};
    end else if (reg_req.addr == ADDR_RX_CNT) begin
      rdata_next = counts[2][31:16];
    end else if (reg_req.addr == ADDR_RX_CNT + 16'h0001) begin
      rdata_next = counts[2][15:0];
    end else if (reg_req.addr == ADDR_ERR_CNT) begin
      rdata_next = counts[1][31:16];
    end else if (reg_req.addr == ADDR_ERR_CNT + 16'h0001) begin
      rdata_next = counts[1][15:0];
    end else if (reg_req.addr == ADDR_TX_CNT) begin
      rdata_next = counts[0][31:16];
    end else if (reg_req.addr == ADDR_TX_CNT + 16'h0001) begin
      rdata_next = counts[0][15:0];
    end else if (reg_req.addr == ADDR_UPTIME) begin
      rdata_next = uptime_reg;
    end else if (reg_req.addr == ADDR_STOP_BITS) begin
      rdata_next = STOP_BITS_VAL;
    end else if (reg_req.addr == ADDR_DATA_BITS) begin
      rdata_next = DATA_BITS_VAL;
    end else if (reg_req.addr == ADDR_PARITY) begin
      rdata_next = PARITY_VAL;
    end else if (reg_req.addr == ADDR_LINE_RATE) begin
      rdata_next = line_rate_setting_reg;
    end else if (reg_req.addr == ADDR_ACTION) begin
      rdata_next = 16'h0000; // Write-only
    end else begin
      err_next = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_reg <= 16'h0000;
      ack_reg   <= 1'b0;
      err_reg   <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      ack_reg   <= ack_next;
      err_reg   <= err_next & ack_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_ack   = ack_reg;
  assign reg_err   = err_reg;

  // ****************************************
  // Line format outputs
  // ****************************************
  assign rate_from_register = (rate_selector_switch == RATE_SW_ALL_OFF);
  assign line_rate_bps      = rate_from_register ? 20'(applied_rate_reg) * RATE_MULT : 20'h0_0000;
  assign char_data_bits     = DATA_BITS_VAL[3:0];
  assign char_stop_bits     = STOP_BITS_VAL[1:0];
  assign parity_on          = PARITY_VAL[0];

  // ****************************************
  // Checks
  // ****************************************
  ident_word_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    reg_req.rd && !reg_req.wr && reg_req.addr == ADDR_IDENTITY |=> reg_rdata == IDENT_WORD && reg_ack)
    else $error("identity word wrong");

  action_decode_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    reg_req.wr && reg_req.addr == ADDR_ACTION && reg_req.wdata == CODE_BOOT
    |=> action_pulse.bootloader ##1 action_pulse.bootloader
    == $past(reg_req.wr && reg_req.addr == ADDR_ACTION && reg_req.wdata == CODE_BOOT))
    else $error("bootloader action not a single pulse");

  action_ignore_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    reg_req.wr && reg_req.addr == ADDR_ACTION && reg_req.wdata != CODE_RESET && reg_req.wdata != CODE_RELOAD
    && reg_req.wdata != CODE_DEFAULTS && reg_req.wdata != CODE_BOOT |=> action_pulse == '0)
    else $error("undefined action triggered");

  addr_switch_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    reg_req.rd && !reg_req.wr && reg_req.addr == ADDR_NODE_SW |=> reg_rdata == {8'h00, $past(address_switch)})
    else $error("address switch readback wrong");

  rx_count_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    frame_events.rx_good && !clear_counters |=> counts[2] == $past(counts[2]) + 32'h0000_0001)
    else $error("received frame not counted");

  counter_clear_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clear_counters && event_vec == 3'b000 |=> counts[0] == 32'h0000_0000 && counts[1] == 32'h0000_0000
    && counts[2] == 32'h0000_0000)
    else $error("counters not cleared on line change");

  uptime_tick_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    second_tick |=> uptime_reg == $past(uptime_reg) + 16'h0001 ##1 $stable(uptime_reg))
    else $error("uptime step wrong");

  rate_output_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    rate_from_register |-> line_rate_bps == 20'({applied_rate_reg, 3'b000}) + 20'({applied_rate_reg, 1'b0}))
    else $error("line rate not ten times register");

  rate_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    reg_req.wr && reg_req.addr == ADDR_LINE_RATE && action_reg != ACT_RELOAD |=> $stable(applied_rate_reg))
    else $error("written rate applied before restart");

  stop_bits_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    reg_req.rd && !reg_req.wr && reg_req.addr == ADDR_STOP_BITS |=> reg_rdata == 16'h0001)
    else $error("stop bit readback wrong");

  rate_off_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !rate_from_register |-> line_rate_bps == 20'h0_0000)
    else $error("register rate used while switch selects");

  err_count_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    frame_events.err_reply && !clear_counters |=> counts[1] == $past(counts[1]) + 32'h0000_0001)
    else $error("error reply not counted");

  tx_count_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    frame_events.tx_frame && !clear_counters |=> counts[0] == $past(counts[0]) + 32'h0000_0001)
    else $error("transmitted frame not counted");

  reload_apply_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    action_reg == ACT_RELOAD |=> applied_rate_reg == $past(line_rate_setting_reg))
    else $error("reload did not apply stored rate");

  defaults_restore_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    action_reg == ACT_DEFAULTS |=> line_rate_setting_reg == LINE_RATE_RESET)
    else $error("defaults did not restore line rate");

  action_ack_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    reg_req.wr && reg_req.addr == ADDR_ACTION |=> reg_ack && !reg_err)
    else $error("action write refused");

endmodule : node_config_regs

// ==== host_model.sv ====
// Register master model that sits in front of the node register bank.
// Assumes the bench calls xfer and drives nothing else on reg_req.
`timescale 1ns/1ps
module host_model
  import node_regs_pkg::*;
(
  input  wire logic        sys_clk,
  output reg_req_t         reg_req,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_ack,
  input  wire logic        reg_err
);
  // Idle bus until the first access
  initial begin
    reg_req = '0;
  end

  // One access: launch at a falling edge, taken at the next rising edge, answer read one cycle on.
  // Action writes carry whatever code the bench hands over
  task automatic xfer(input logic wr, input logic [15:0] addr, input logic [15:0] wdata,
                      output logic [15:0] rdata, output logic err, output logic ack);
    @(negedge sys_clk);
    reg_req = '{rd: ~wr, wr: wr, addr: addr, wdata: wdata};
    @(negedge sys_clk);
    reg_req.rd = 1'b0;
    reg_req.wr = 1'b0;
    reg_req.addr = ~addr;  // Released lines do not keep the old value
    reg_req.wdata = ~wdata;
    ack = reg_ack;
    err = reg_err;
    rdata = reg_rdata;
  endtask : xfer
endmodule : host_model

// ==== tb_top.sv ====
// Self-checking bench for the node register bank.
// Assumes host_model drives the register port and the bench drives switches and frame events.
`timescale 1ns/1ps
module tb_top;
  import node_regs_pkg::*;
  // ****************************************
  // Signals and model state
  // ****************************************
  logic          sys_clk = 1'b0;
  logic          reset_n = 1'b0;
  reg_req_t      reg_req;
  logic [15:0]   reg_rdata;
  logic          reg_ack;
  logic          reg_err;
  logic [7:0]    address_switch;
  logic [7:0]    config_switch;
  logic [2:0]    rate_selector_switch;
  frame_events_t frame_events;
  action_pulse_t action_pulse;
  logic [19:0]   line_rate_bps;
  logic          rate_from_register;
  logic [3:0]    char_data_bits;
  logic [1:0]    char_stop_bits;
  logic          parity_on;
  int            num_errors = 0;
  int            checks_done = 0;
  int            rx_n, er_n, tx_n, rate_set, rate_app;
  logic [15:0]   rd_v, t0;
  logic          rd_e, rd_a;
  logic [15:0]   codes [4] = '{CODE_RESET, CODE_RELOAD, CODE_DEFAULTS, CODE_BOOT};

  // 10 MHz clock
  always #50 sys_clk = ~sys_clk;

  node_config_regs #(.MODULE_TYPE(8'h3C), .FW_MAJOR(2), .FW_MINOR(5), .SECOND_CYCLES_P(10)) u_node_config_regs (
    .sys_clk(sys_clk), .reset_n(reset_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_ack(reg_ack), .reg_err(reg_err), .address_switch(address_switch),
    .config_switch(config_switch), .rate_selector_switch(rate_selector_switch),
    .frame_events(frame_events), .action_pulse(action_pulse), .line_rate_bps(line_rate_bps),
    .rate_from_register(rate_from_register), .char_data_bits(char_data_bits),
    .char_stop_bits(char_stop_bits), .parity_on(parity_on));

  host_model u_host_model (.sys_clk(sys_clk), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_ack(reg_ack), .reg_err(reg_err));

  // ****************************************
  // Compare and access helpers
  // ****************************************
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Read; a refused access is judged on ack and err alone
  task automatic rd(input logic [15:0] addr, input logic [15:0] exp, input logic e_err = 1'b0);
    u_host_model.xfer(1'b0, addr, 16'h0000, rd_v, rd_e, rd_a);
    check({rd_a, rd_e, (e_err ? 16'h0000 : rd_v)}, {1'b1, e_err, (e_err ? 16'h0000 : exp)});
  endtask : rd

  task automatic wr(input logic [15:0] addr, input logic [15:0] data, input logic e_err);
    u_host_model.xfer(1'b1, addr, data, rd_v, rd_e, rd_a);
    check({rd_a, rd_e}, {1'b1, e_err});
  endtask : wr

  // Action write; the pulse stands in the answer cycle
  task automatic act(input logic [15:0] code, input logic [3:0] exp);
    wr(ADDR_ACTION, code, 1'b0);
    check(action_pulse, exp);
  endtask : act

  task automatic rd32(input logic [15:0] base, input logic [31:0] exp);
    rd(base, exp[31:16]);
    rd(base + 16'h0001, exp[15:0]);
  endtask : rd32

  // Applied rate seen at the ports
  task automatic chk_rate();
    check({rate_from_register, line_rate_bps},
          {rate_selector_switch == 3'h0, (rate_selector_switch == 3'h0) ? 20'(rate_app * 10) : 20'h0_0000});
  endtask : chk_rate

  // Random frame events for a stretch of cycles
  task automatic events(input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge sys_clk);
      frame_events = 3'($urandom);
      rx_n += frame_events.rx_good;
      er_n += frame_events.err_reply;
      tx_n += frame_events.tx_frame;
    end
    @(negedge sys_clk);
    frame_events = '0;
  endtask : events

  task automatic results();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    address_switch = 8'h00;
    config_switch = 8'h00;
    rate_selector_switch = 3'h0;
    frame_events = '0;
    void'($urandom(36527));
    rx_n = 0;
    er_n = 0;
    tx_n = 0;
    rate_set = 7680;
    rate_app = 7680;
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    reset_n = 1'b1;
    rd(ADDR_IDENTITY, {8'h19, 8'h3C});
    rd(ADDR_STOP_BITS, 16'h0001);
    rd(ADDR_DATA_BITS, 16'h0008);
    rd(ADDR_PARITY, 16'h0000);
    check({char_data_bits, char_stop_bits, parity_on}, {4'h8, 2'h1, 1'b0});
    rd(ADDR_LINE_RATE, 16'h1E00);
    chk_rate();
    rd(16'h7000, 16'h0000, 1'b1);
    wr(ADDR_IDENTITY, 16'($urandom), 1'b1);
    for (int i = 0; i < 4; i++) begin
      address_switch = 8'($urandom);
      config_switch = 8'($urandom);
      rd(ADDR_NODE_SW, {8'h00, address_switch});
      rd(ADDR_CFG_SW, {8'h00, config_switch});
    end
    events(60);
    rd32(ADDR_RX_CNT, rx_n);
    rd32(ADDR_ERR_CNT, er_n);
    rd32(ADDR_TX_CNT, tx_n);
    // Written rate waits for a reload, then all four actions in turn
    rate_set = 1000 + $urandom_range(0, 5000);
    wr(ADDR_LINE_RATE, 16'(rate_set), 1'b0);
    chk_rate();
    rd(ADDR_LINE_RATE, 16'(rate_set));
    for (int k = 0; k < 4; k++) begin
      act(codes[k], 4'b1000 >> k);
      if (k == 1)
        rate_app = rate_set;
      if (k == 2)
        rate_set = 7680;
      repeat (2) @(negedge sys_clk);
      chk_rate();
    end
    rd(ADDR_LINE_RATE, 16'h1E00);
    act(16'h0500 + 16'($urandom_range(0, 255)), 4'b0000);
    rd32(ADDR_RX_CNT, 32'h0000_0000);
    rd32(ADDR_TX_CNT, 32'h0000_0000);
    // Rate switch takes over the line rate and clears the counters
    events(30);
    rate_selector_switch = 3'h1 + 3'($urandom_range(0, 6));
    repeat (2) @(negedge sys_clk);
    chk_rate();
    rd32(ADDR_ERR_CNT, 32'h0000_0000);
    rate_selector_switch = 3'h0;
    repeat (2) @(negedge sys_clk);
    chk_rate();
    // Uptime advances one per second span
    u_host_model.xfer(1'b0, ADDR_UPTIME, 16'h0000, t0, rd_e, rd_a);
    repeat (98) @(negedge sys_clk);
    u_host_model.xfer(1'b0, ADDR_UPTIME, 16'h0000, rd_v, rd_e, rd_a);
    check(16'(rd_v - t0), 16'h000A);
    // Second reset in mid-run
    events(20);
    reset_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    reset_n = 1'b1;
    rate_app = 7680;
    rd(ADDR_UPTIME, 16'h0000);
    rd32(ADDR_RX_CNT, 32'h0000_0000);
    chk_rate();
    results();
  end

  // Watchdog well beyond the expected run
  initial begin
    #(100 * 20000);
    num_errors++;
    results();
  end
endmodule : tb_top
